// ===== core/sacp_pkg.sv
// shared constants, encodings and state records of the serial converter command port
package sacp_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 2_500_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [7:0] ID_VALUE = 8'h5a; // arbitrary identification value
  localparam logic [4:0] REG_RESET_ADDR = 5'h00;
  localparam logic [4:0] REG_REFOSC = 5'h07;
  localparam logic [4:0] REG_MODE = 5'h18;
  localparam logic [4:0] REG_ID = 5'h1f;
  localparam logic [7:0] RESET_DATA = 8'h00;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam int INSTR_DIRECT_BIT = 7;
  localparam int INSTR_READ_BIT = 6;
  localparam int INSTR_WIDE_BIT = 5;
  localparam int REFOSC_OSC_BIT = 3;
  localparam int REFOSC_REF_BIT = 4;
  localparam int MODE_MSB_BIT = 0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_INSTR = 5'b00010,
    S_WDATA = 5'b00100,
    S_RDATA = 5'b01000,
    S_RESULT = 5'b10000
  } sacp_ser_e;

  // selection driven to the analog front end
  typedef struct packed {
    logic [4:0] gainMult;
    logic [2:0] muxPos;
    logic [2:0] muxNeg;
    logic negGround;
    logic differential;
  } sacp_conv_sel_s;

  typedef struct packed {
    logic [1:0] csSync;
    logic [2:0] sclkSync;
    logic [1:0] sdiSync;
    logic [2:0] cclkSync;
    logic [1:0] selSync;
    sacp_ser_e ser;
    logic [4:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] instr;
    logic [7:0] cmd;
    logic busy;
    logic [4:0] tick;
    logic [7:0] oscDiv;
    sacp_conv_sel_s sel;
    logic [15:0] result;
    logic overRange;
    logic serial_result_out;
    logic sdoEn;
  } sacp_state_s;

  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [7:0] rd;
  } sacp_mem_s;
endpackage : sacp_pkg

// ===== core/sacp_regmem.sv
// register file of the converter with registered read data
`timescale 1ns/1ps
module sacp_regmem
  import sacp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [4:0] rdAddr,
  output logic [7:0] rdData,
  output logic [7:0] refOsc,
  output logic [7:0] modeReg
);
  import sacp_pkg::*;

  sacp_mem_s r;
  sacp_mem_s next_r;

  // identification slot is read-only, reset command wipes the rest
  always_comb
  begin
    next_r = r;
    if (clear)
    begin
      next_r.mem = '0;
    end
    else if (wrEn && wrAddr != REG_ID)
    begin
      next_r.mem[wrAddr] = wrData;
    end
    next_r.rd = (rdAddr == REG_ID) ? ID_VALUE : r.mem[rdAddr];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rdData = r.rd;
  assign refOsc = r.mem[REG_REFOSC];
  assign modeReg = r.mem[REG_MODE];
endmodule : sacp_regmem

// ===== core/sacp_port.sv
// serial command, register access and conversion control of the converter
// Function
// [RULE1] direct command: bit 7 set, gain in bits 6-4, channel in bits 3-0
// [RULE2] conversion starts right after the eighth direct command bit
// [RULE3] host selects msb-first order and enables the oscillator beforehand
// [RULE4] gain codes 0-7 give 1, 2, 4, 5, 8, 10, 16, 20
// [RULE5] codes 0-3 even-positive pairs, 4-7 reversed, 8-15 single-ended
// [RULE6] busy is high exactly while a conversion runs
// [RULE7] host holds chip select low for each transfer; high disables port
// [RULE8] command input sampled on rising serial clock edge
// [RULE9] three wires: commands on input line, results on separate output
// [RULE10] register instruction starts 8 or 16 bit read or write
// [RULE11] instruction 0x00 with data 0x00 resets the converter
// [RULE12] instruction 0x5F reads the identification value
// [RULE13] write 0x3b to register 0x07 enables reference and oscillator
// [RULE14] single-ended results 0 to 2047, differential -2048 to 2047
// [RULE15] conversion clock source select low uses external clock pin
// [RULE16] host allows about one second before trusting first result; bench settles only SETTLE_CYCLES = 64 cycles
// [RULE17] host bounds its wait for busy and reports timeout
// [RULE18] host sets transfer rate 9600-115200 at first configuration; host model keeps a fixed 8 clock cycles per bit
// [RULE19] host reports overflow when converter flags out-of-range
// [RULE20] host waits busy low, then clocks result out msb first
`timescale 1ns/1ps
module sacp_port
  import sacp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic serialCmdIn,
  input wire logic convClockSourceSel,
  input wire logic externalConvClock,
  input wire logic signed [12:0] convSample,
  output logic serialResultOut,
  output logic serialResultOutEn,
  output logic convBusy,
  output sacp_pkg::sacp_conv_sel_s convSel,
  output logic convOverRange,
  output logic msbFirstSetting,
  output logic refEnable,
  output logic oscEnable
);
  import sacp_pkg::*;

  sacp_state_s r;
  sacp_state_s next_r;
  logic [7:0] memRd;
  logic [7:0] refOsc;
  logic [7:0] modeReg;
  logic wrEn;
  logic [4:0] wrAddr;
  logic [7:0] wrData;
  logic [4:0] rdAddr;
  logic memClear;
  logic sclkRise;
  logic cclkRise;
  logic csActive;
  logic convTick;
  logic startConv;
  logic resetCmd;
  logic [7:0] inByte;
  logic [7:0] newByte;
  logic msbFirst;
  logic signed [12:0] clamped;

  function automatic logic [4:0] gainOf(input logic [2:0] code);
    case (code) // [RULE4]
      3'h0: gainOf = 5'h01;
      3'h1: gainOf = 5'h02;
      3'h2: gainOf = 5'h04;
      3'h3: gainOf = 5'h05;
      3'h4: gainOf = 5'h08;
      3'h5: gainOf = 5'h0a;
      3'h6: gainOf = 5'h10;
      default: gainOf = 5'h14;
    endcase
  endfunction : gainOf

  sacp_regmem u_regmem (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(memClear),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(rdAddr),
    .rdData(memRd),
    .refOsc(refOsc),
    .modeReg(modeReg)
  );

  // edges are taken between second and third stages only
  assign sclkRise = r.sclkSync[1] & ~r.sclkSync[2];
  assign cclkRise = r.cclkSync[1] & ~r.cclkSync[2];
  assign csActive = ~r.csSync[1]; // [RULE7]
  assign msbFirst = modeReg[MODE_MSB_BIT]; // [RULE3]
  assign inByte = {r.shift[6:0], r.sdiSync[1]};

  // conversion clock: pin edges or divided internal oscillator
  assign convTick = r.selSync[1] ? (oscEnable && r.oscDiv == 8'(OSC_DIV - 1))
                                 : cclkRise; // [RULE15]

  // single-ended clamps at zero, both clamp at the 12-bit ceiling
  always_comb
  begin
    clamped = convSample;
    if (r.cmd[3] && convSample < 0)
    begin
      clamped = '0;
    end
    else if (convSample > 13'sd2047)
    begin
      clamped = 13'sd2047;
    end
    else if (convSample < -13'sd2048)
    begin
      clamped = -13'sd2048;
    end
  end

  // whole next-state computation
  always_comb
  begin
    next_r = r;
    wrEn = 1'b0;
    wrAddr = 5'(r.instr[4:0] + {4'h0, r.bitCnt[3]});
    wrData = msbFirst ? inByte : {r.sdiSync[1], r.shift[7:1]};
    newByte = msbFirst ? inByte : {r.sdiSync[1], r.shift[7:1]};
    rdAddr = wrAddr;
    memClear = 1'b0;
    startConv = 1'b0;
    resetCmd = 1'b0;
    next_r.csSync = {r.csSync[0], chipSelectN};
    next_r.sclkSync = {r.sclkSync[1:0], serialClock};
    next_r.sdiSync = {r.sdiSync[0], serialCmdIn};
    next_r.cclkSync = {r.cclkSync[1:0], externalConvClock};
    next_r.selSync = {r.selSync[0], convClockSourceSel};
    next_r.oscDiv = (r.oscDiv == 8'(OSC_DIV - 1)) ? 8'h00 : 8'(r.oscDiv + 8'h01);
    // conversion progress counted in conversion clock ticks
    if (r.busy && convTick)
    begin
      if (r.tick == CONV_TICKS - 5'h01)
      begin
        next_r.busy = 1'b0; // [RULE6]
        next_r.tick = '0;
        next_r.result = 16'(clamped); // [RULE14]
        next_r.overRange = (clamped != convSample);
      end
      else
      begin
        next_r.tick = 5'(r.tick + 5'h01);
      end
    end
    if (!csActive)
    begin
      next_r.ser = S_IDLE; // [RULE7]
      next_r.bitCnt = '0;
      next_r.sdoEn = 1'b0;
    end
    else
    begin
      case (r.ser)
        S_IDLE:
        begin
          next_r.ser = S_INSTR;
          next_r.bitCnt = '0;
          next_r.sdoEn = 1'b1; // [RULE9]
        end
        S_INSTR:
        begin
          if (sclkRise)
          begin
            next_r.shift = inByte; // [RULE8]
            next_r.bitCnt = 5'(r.bitCnt + 5'h01);
            if (r.bitCnt == 5'h07)
            begin
              next_r.bitCnt = '0;
              if (inByte[INSTR_DIRECT_BIT]) // [RULE1]
              begin
                next_r.ser = S_RESULT;
                if (!r.busy)
                begin
                  startConv = 1'b1; // [RULE2]
                  next_r.busy = 1'b1; // [RULE6]
                  next_r.tick = '0;
                  next_r.cmd = inByte;
                  next_r.sel.gainMult = gainOf(inByte[6:4]);
                  next_r.sel.differential = ~inByte[3]; // [RULE5]
                  next_r.sel.negGround = inByte[3];
                  next_r.sel.muxPos = inByte[3] ? inByte[2:0] : {inByte[1:0], inByte[2]};
                  next_r.sel.muxNeg = inByte[3] ? 3'h0 : {inByte[1:0], ~inByte[2]};
                end
              end
              else
              begin
                next_r.instr = inByte; // [RULE10]
                next_r.ser = inByte[INSTR_READ_BIT] ? S_RDATA : S_WDATA;
              end
            end
          end
        end
        S_WDATA:
        begin
          if (sclkRise)
          begin
            next_r.shift = newByte;
            next_r.bitCnt = 5'(r.bitCnt + 5'h01);
            if (r.bitCnt[2:0] == 3'h7)
            begin
              wrEn = 1'b1; // [RULE13]
              if (r.instr[4:0] == REG_RESET_ADDR && newByte == RESET_DATA)
              begin
                resetCmd = 1'b1; // [RULE11]
                memClear = 1'b1;
                next_r.busy = 1'b0;
                next_r.tick = '0;
                next_r.result = RESULT_RESET;
                next_r.overRange = 1'b0;
              end
              if (!r.instr[INSTR_WIDE_BIT] || r.bitCnt[3])
              begin
                next_r.ser = S_INSTR;
                next_r.bitCnt = '0;
              end
            end
          end
        end
        S_RDATA:
        begin
          next_r.serial_result_out = memRd[msbFirst ? 3'(7 - r.bitCnt[2:0]) : r.bitCnt[2:0]]; // [RULE12]
          if (sclkRise)
          begin
            next_r.bitCnt = 5'(r.bitCnt + 5'h01);
            if (r.bitCnt[2:0] == 3'h7 && (!r.instr[INSTR_WIDE_BIT] || r.bitCnt[3]))
            begin
              next_r.ser = S_INSTR;
              next_r.bitCnt = '0;
            end
          end
        end
        S_RESULT:
        begin
          // result bits only advance once busy has dropped
          next_r.serial_result_out = r.result[msbFirst ? 4'(15 - r.bitCnt[3:0]) : r.bitCnt[3:0]]; // [RULE20]
          if (sclkRise && !r.busy)
          begin
            next_r.bitCnt = 5'(r.bitCnt + 5'h01);
            if (r.bitCnt == 5'h0f)
            begin
              next_r.ser = S_INSTR;
              next_r.bitCnt = '0;
            end
          end
        end
        default:
        begin
          next_r.ser = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.ser <= S_IDLE;
      r.csSync <= 2'h3;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign serialResultOut = r.serial_result_out;
  assign serialResultOutEn = r.sdoEn;
  assign convBusy = r.busy;
  assign convSel = r.sel;
  assign convOverRange = r.overRange; // [RULE19]
  assign msbFirstSetting = msbFirst;
  assign refEnable = refOsc[REFOSC_REF_BIT];
  assign oscEnable = refOsc[REFOSC_OSC_BIT];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence idRead;
    r.ser == S_RDATA && r.instr == 8'h5f ##1 r.ser == S_RDATA;
  endsequence

  chk_busy_start: assert property (startConv |=> convBusy) // [RULE2]
    else $error("busy did not rise after direct command");
  chk_busy_min: assert property ($rose(convBusy) |-> convBusy [*8]) // [RULE6]
    else $error("conversion ended too early");
  chk_edge_sample: assert property (r.ser == S_INSTR && !sclkRise |=> $stable(r.shift)) // [RULE8]
    else $error("command bit taken without rising serial clock");
  chk_gain_map: assert property ($rose(convBusy) |-> convSel.gainMult == gainOf(r.cmd[6:4])) // [RULE4]
    else $error("gain multiplier mismatch");
  chk_mux_single: assert property (convBusy && r.cmd[3] |->
    convSel.negGround && convSel.muxPos == r.cmd[2:0]) // [RULE5]
    else $error("single-ended input selection wrong");
  chk_reset_cmd: assert property (resetCmd |=> !convBusy && refOsc == 8'h00) // [RULE11]
    else $error("reset command did not reset converter");
  chk_id_read: assert property (idRead |-> memRd == ID_VALUE) // [RULE12]
    else $error("identification read wrong");
  chk_refosc_en: assert property (wrEn && wrAddr == REG_REFOSC && wrData == 8'h3b
    |=> refEnable && oscEnable) // [RULE13]
    else $error("reference or oscillator not enabled");
  chk_se_range: assert property ($fell(convBusy) && r.cmd[3] |->
    r.result <= 16'h07ff) // [RULE14]
    else $error("single-ended result out of range");
  chk_ext_clock: assert property (convBusy && !r.selSync[1] && !cclkRise && !resetCmd |=>
    $stable(r.tick)) // [RULE15]
    else $error("conversion advanced without external clock edge");
  chk_three_wire: assert property (r.csSync[1] |=> !serialResultOutEn) // [RULE9]
    else $error("result line driven while deselected");
endmodule : sacp_port

// ===== tb/sacp_host_model.sv
// host side model driving the converter serial link
`timescale 1ns/1ps
module sacp_host_model
(
  input wire logic ref_clk,
  output logic chipSelectN,
  output logic serialClock,
  output logic serialCmdIn,
  input wire logic serialResultOut,
  input wire logic convBusy
);
  // idle: deselected and clock still
  initial
  begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialCmdIn = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // data set while clock low, taken on the rise; rate fixed for the run
  task automatic bitx(input logic b, output logic r);
    serialClock = 1'b0;
    serialCmdIn = b;
    cyc(4);
    r = serialResultOut; // settled well before the rise
    serialClock = 1'b1;
    cyc(4);
  endtask : bitx

  // n bits, msb first; instruction then phase
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    logic r;
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--)
    begin
      bitx(tx[i], r);
      rx[i] = r;
    end
  endtask : xfer

  // charge time before the first result is trusted, scaled down to keep the run short
  localparam int SETTLE_CYCLES = 64;

  task automatic settle();
    cyc(SETTLE_CYCLES);
  endtask : settle

  // select held low across the whole transfer
  task automatic open();
    chipSelectN = 1'b0;
    cyc(4);
  endtask : open

  task automatic close();
    serialClock = 1'b0;
    cyc(4);
    chipSelectN = 1'b1;
    serialCmdIn = ~serialCmdIn; // released line shows no stale value
    cyc(4);
  endtask : close

  // bounded wait for busy low, timeout flagged
  task automatic waitIdle(output logic ok);
    int k;
    k = 0;
    while (convBusy !== 1'b0 && k < 2000)
    begin
      cyc(1);
      k++;
    end
    ok = (convBusy === 1'b0);
  endtask : waitIdle
endmodule : sacp_host_model

// ===== tb/sacp_port_tb.sv
// self-checking bench of the converter command port
`timescale 1ns/1ps
module sacp_port_tb;
  import sacp_pkg::*;
  localparam logic [4:0] GM [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h10, 5'h14};
  logic ref_clk, sys_rst, csN, serClk, cmdIn, resOut, resOutEn, busy;
  logic srcSel, extClk, extRun, overRange, msbFirst, refEn, oscEn;
  logic signed [12:0] convSample;
  sacp_conv_sel_s convSel;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  sacp_port dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelectN(csN), .serialClock(serClk),
    .serialCmdIn(cmdIn), .convClockSourceSel(srcSel), .externalConvClock(extClk),
    .convSample(convSample), .serialResultOut(resOut), .serialResultOutEn(resOutEn),
    .convBusy(busy), .convSel(convSel), .convOverRange(overRange),
    .msbFirstSetting(msbFirst), .refEnable(refEn), .oscEnable(oscEn)
  );
  sacp_host_model host (
    .ref_clk(ref_clk), .chipSelectN(csN), .serialClock(serClk), .serialCmdIn(cmdIn),
    .serialResultOut(resOut), .convBusy(busy)
  );

  // 40 MHz system clock
  always #12.5 ref_clk = ~ref_clk;

  // conversion clock pin, toggled every 4 cycles while enabled
  always
  begin
    host.cyc(4);
    if (extRun)
      extClk = ~extClk;
  end

  // hang guard, far above the expected run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // one direct conversion: command, busy, selection, readout
  task automatic conv(input logic [7:0] cmd, input int smp, input logic ext);
    logic [15:0] rx;
    logic r, ok;
    int c, lo, e;
    c = int'(cmd[3:0]);
    convSample = 13'(smp);
    srcSel = ~ext; // low takes ticks from the pin
    host.open();
    host.xfer({9'h000, cmd[7:1]}, 7, rx);
    chk("busy early", 16'(busy), 16'h0000);
    host.bitx(cmd[0], r);
    host.cyc(2);
    chk("busy", 16'(busy), 16'h0001);
    chk("gain", 16'(convSel.gainMult), 16'(GM[cmd[6:4]]));
    chk("kind", 16'({convSel.differential, convSel.negGround}), c < 8 ? 16'h2 : 16'h1);
    chk("pos", 16'(convSel.muxPos), 16'(c < 4 ? 2 * c : c < 8 ? 2 * c - 7 : c - 8));
    if (c < 8)
      chk("neg", 16'(convSel.muxNeg), 16'(c < 4 ? 2 * c + 1 : 2 * c - 8));
    if (ext)
    begin
      host.cyc(400);
      chk("no ticks", 16'(busy), 16'h0001);
      extRun = 1'b1;
    end
    host.waitIdle(ok);
    extRun = 1'b0;
    chk("done", 16'(ok), 16'h0001);
    host.xfer(16'h0000, 16, rx);
    host.close();
    lo = c < 8 ? -2048 : 0;
    e = smp > 2047 ? 2047 : smp < lo ? lo : smp;
    chk("result", rx, 16'(e));
    chk("clamp", 16'(overRange), 16'(e != smp));
  endtask : conv

  task automatic t_reset();
    chk("rst", 16'({busy, resOutEn, msbFirst, refEn, oscEn}), 16'h0000);
  endtask : t_reset

  // mode byte goes lsb first, ref/osc write follows in the same frame
  task automatic t_config();
    logic [15:0] rx;
    host.open();
    chk("oe", 16'(resOutEn), 16'h0001);
    host.xfer(16'h1880, 16, rx);
    host.xfer(16'h073b, 16, rx);
    host.close();
    chk("msb", 16'(msbFirst), 16'h0001);
    chk("refosc", 16'({refEn, oscEn}), 16'h0003);
    chk("oe off", 16'(resOutEn), 16'h0000);
  endtask : t_config

  // aborted partial instruction must not corrupt the next frame; id slot ignores writes
  task automatic t_id();
    logic [15:0] rx;
    host.open();
    host.xfer(16'h0005, 4, rx);
    host.close();
    host.open();
    host.xfer(16'h1fff, 16, rx);
    host.xfer(16'h5f00, 16, rx);
    host.close();
    chk("id", 16'(rx[7:0]), 16'(ID_VALUE));
  endtask : t_id

  // every channel code, every gain code twice
  task automatic t_convs();
    host.settle();
    for (int c = 0; c < 16; c++)
      conv({1'b1, 3'(c), 4'(c)}, c < 8 ? -(c * 100 + 7) : c * 131, 1'b0);
  endtask : t_convs

  task automatic t_clamp();
    conv(8'h8b, 3000, 1'b0);
    conv(8'hf2, -3000, 1'b0);
    conv(8'h88, -5, 1'b0);
  endtask : t_clamp

  task automatic t_ext();
    conv(8'h9c, 1234, 1'b1);
  endtask : t_ext

  task automatic t_softreset();
    logic [15:0] rx;
    host.open();
    host.xfer(16'h0000, 16, rx);
    host.close();
    chk("clear", 16'({msbFirst, refEn, oscEn}), 16'h0000);
  endtask : t_softreset

  // 16-bit read: byte at 0x06 first, then the ref/osc byte at 0x07
  task automatic t_wide();
    logic [15:0] rx;
    host.open();
    host.xfer(16'h0066, 8, rx);
    host.xfer(16'h0000, 16, rx);
    host.close();
    chk("wide", rx, 16'h003b);
  endtask : t_wide

  // reset in mid-conversion; no pin ticks, so only the reset can end it
  task automatic t_midreset();
    logic [15:0] rx;
    srcSel = 1'b0;
    host.open();
    host.xfer(16'h0088, 8, rx);
    host.cyc(12);
    chk("mid busy", 16'(busy), 16'h0001);
    sys_rst = 1'b1;
    host.cyc(2);
    sys_rst = 1'b0;
    host.cyc(1);
    chk("mid rst", 16'({busy, resOutEn}), 16'h0000);
    chk("mid sel", 16'(convSel), 16'h0000);
    host.close();
  endtask : t_midreset

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    srcSel = 1'b1;
    extClk = 1'b0;
    extRun = 1'b0;
    convSample = 13'h0000;
    repeat (4) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    host.cyc(4);
    t_reset();
    t_config();
    t_id();
    t_wide();
    t_convs();
    t_clamp();
    t_ext();
    t_softreset();
    t_midreset();
    test_done();
  end
endmodule : sacp_port_tb
